// *** lia_link_interrupt_aggregator.sv ***
/*
 Interrupt aggregation unit: control and status registers, sticky event
 flags, global interrupt output toward the host controller.
 Assumes a byte register port driven by the serial control bus logic; one
 access per cycle at most; events synchronous to clk.
 Held flags clear on any status read; an event in that cycle wins.
*/
`timescale 1ns/1ns
module lia_link_interrupt_aggregator (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // register port
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_rvalid,
    // event sources, one-cycle pulses or levels
    input  wire logic       indirect_done,
    input  wire logic       receiver_found,
    input  wire logic       downstream_irq,
    input  wire logic       key_list_ready,
    input  wire logic       key_ready,
    input  wire logic       auth_fail,
    input  wire logic       auth_pass,
    // interrupt toward the controller
    output logic            irq_out
);

    // =========================================================
    // reset release
    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // =========================================================
    // address decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    logic ctl_sel;
    logic sts_sel;

    assign ctl_sel = hit(reg_addr, lia_pkg::OFF_INTERRUPT_CONTROL);
    assign sts_sel = hit(reg_addr, lia_pkg::OFF_INTERRUPT_STATUS);

    // =========================================================
    // access strobes
    logic ctl_wr;
    logic sts_rd;

    assign ctl_wr = reg_wr && ctl_sel;
    assign sts_rd = reg_rd && sts_sel;

    // =========================================================
    // interrupt control register
    logic [7:0] interrupt_control_r;
    logic [7:0] interrupt_control_nxt;

    always_comb begin
        interrupt_control_nxt = interrupt_control_r;
        if (ctl_wr) begin
            interrupt_control_nxt = reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            interrupt_control_r <= lia_pkg::RST_INTERRUPT_CONTROL;
        end else begin
            interrupt_control_r <= interrupt_control_nxt;
        end
    end

    // =========================================================
    // control fields
    logic indirect_done_enable;
    logic receiver_found_enable;
    logic downstream_irq_enable;
    logic key_list_ready_enable;
    logic key_ready_enable;
    logic auth_fail_enable;
    logic auth_pass_enable;
    logic global_enable;

    assign indirect_done_enable  =
        interrupt_control_r[lia_pkg::BIT_INDIRECT_DONE];

    assign receiver_found_enable =
        interrupt_control_r[lia_pkg::BIT_RECEIVER_FOUND];

    assign downstream_irq_enable =
        interrupt_control_r[lia_pkg::BIT_DOWNSTREAM_IRQ];

    assign key_list_ready_enable =
        interrupt_control_r[lia_pkg::BIT_KEY_LIST_READY];

    assign key_ready_enable      =
        interrupt_control_r[lia_pkg::BIT_KEY_READY];

    assign auth_fail_enable      =
        interrupt_control_r[lia_pkg::BIT_AUTH_FAIL];

    assign auth_pass_enable      =
        interrupt_control_r[lia_pkg::BIT_AUTH_PASS];

    assign global_enable         =
        interrupt_control_r[lia_pkg::BIT_GLOBAL];

    // =========================================================
    // sticky event flags
    logic [lia_pkg::NUM_EVENTS-1:0] event_vec;
    logic [lia_pkg::NUM_EVENTS-1:0] clear_vec;
    logic [lia_pkg::NUM_EVENTS-1:0] flag_vec;

    // =========================================================
    // event sources by bit
    always_comb begin
        event_vec = '0;
        event_vec[lia_pkg::BIT_INDIRECT_DONE-1]  = indirect_done;
        event_vec[lia_pkg::BIT_RECEIVER_FOUND-1] = receiver_found;
        event_vec[lia_pkg::BIT_DOWNSTREAM_IRQ-1] = downstream_irq;
        event_vec[lia_pkg::BIT_KEY_LIST_READY-1] = key_list_ready;
        event_vec[lia_pkg::BIT_KEY_READY-1]      = key_ready;
        event_vec[lia_pkg::BIT_AUTH_FAIL-1]      = auth_fail;
        event_vec[lia_pkg::BIT_AUTH_PASS-1]      = auth_pass;
    end

    // =========================================================
    // status read clears all held flags
    assign clear_vec = {lia_pkg::NUM_EVENTS{sts_rd}};

    // =========================================================
    // sticky latch
    lia_event_latch u_latch (
        .clk      (clk),
        .rst_n    (rst_n_r),
        .event_in (event_vec),
        .clear_in (clear_vec),
        .flag_out (flag_vec)
    );

    // =========================================================
    // held flags by source
    logic indirect_done_flag;
    logic receiver_found_flag;
    logic downstream_irq_flag;
    logic key_list_ready_flag;
    logic key_ready_flag;
    logic auth_fail_flag;
    logic auth_pass_flag;

    assign indirect_done_flag  =
        flag_vec[lia_pkg::BIT_INDIRECT_DONE-1];
    assign receiver_found_flag =
        flag_vec[lia_pkg::BIT_RECEIVER_FOUND-1];
    assign downstream_irq_flag =
        flag_vec[lia_pkg::BIT_DOWNSTREAM_IRQ-1];
    assign key_list_ready_flag =
        flag_vec[lia_pkg::BIT_KEY_LIST_READY-1];
    assign key_ready_flag      =
        flag_vec[lia_pkg::BIT_KEY_READY-1];
    assign auth_fail_flag      =
        flag_vec[lia_pkg::BIT_AUTH_FAIL-1];
    assign auth_pass_flag      =
        flag_vec[lia_pkg::BIT_AUTH_PASS-1];

    // =========================================================
    // per-source pending, flag and enable both set
    logic indirect_done_pending;
    logic receiver_found_pending;
    logic downstream_irq_pending;
    logic key_list_ready_pending;
    logic key_ready_pending;
    logic auth_fail_pending;
    logic auth_pass_pending;

    assign indirect_done_pending  =
        indirect_done_flag && indirect_done_enable;

    assign receiver_found_pending =
        receiver_found_flag && receiver_found_enable;

    assign downstream_irq_pending =
        downstream_irq_flag && downstream_irq_enable;

    assign key_list_ready_pending =
        key_list_ready_flag && key_list_ready_enable;

    assign key_ready_pending      =
        key_ready_flag && key_ready_enable;

    assign auth_fail_pending      =
        auth_fail_flag && auth_fail_enable;

    assign auth_pass_pending      =
        auth_pass_flag && auth_pass_enable;

    // =========================================================
    // enabled-event summary
    logic any_enabled;

    always_comb begin
        any_enabled =
            indirect_done_pending  ||
            receiver_found_pending ||
            downstream_irq_pending ||
            key_list_ready_pending ||
            key_ready_pending      ||
            auth_fail_pending      ||
            auth_pass_pending;
    end

    // =========================================================
    // status image
    logic [7:0] interrupt_status;

    always_comb begin
        interrupt_status = lia_pkg::RST_INTERRUPT_STATUS;
        interrupt_status[lia_pkg::BIT_INDIRECT_DONE]  = indirect_done_flag;
        interrupt_status[lia_pkg::BIT_RECEIVER_FOUND] = receiver_found_flag;
        interrupt_status[lia_pkg::BIT_DOWNSTREAM_IRQ] = downstream_irq_flag;
        interrupt_status[lia_pkg::BIT_KEY_LIST_READY] = key_list_ready_flag;
        interrupt_status[lia_pkg::BIT_KEY_READY]      = key_ready_flag;
        interrupt_status[lia_pkg::BIT_AUTH_FAIL]      = auth_fail_flag;
        interrupt_status[lia_pkg::BIT_AUTH_PASS]      = auth_pass_flag;
        interrupt_status[lia_pkg::BIT_GLOBAL]         = any_enabled;
    end

    // =========================================================
    // read path
    logic [7:0] reg_rdata_nxt;

    always_comb begin
        reg_rdata_nxt = lia_pkg::RD_UNMAPPED;
        if (ctl_sel) begin
            reg_rdata_nxt = interrupt_control_r;
        end else if (sts_sel) begin
            reg_rdata_nxt = interrupt_status;
        end
    end

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
        end
    end

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= reg_rdata_nxt;
        end
    end

    // =========================================================
    // interrupt output
    logic irq_nxt;

    always_comb begin
        irq_nxt = global_enable && any_enabled;
    end

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= irq_nxt;
        end
    end

endmodule

// *** lia_pkg.sv ***
/*
 Package for the link interrupt aggregator: register offsets, field
 positions, reset values and register-port encodings.
 Assumes a byte-wide register port from the device's serial control logic.
*/
package lia_pkg;

    // =========================================================
    // register offsets
    localparam logic [7:0] OFF_INTERRUPT_CONTROL = 8'hc6;
    localparam logic [7:0] OFF_INTERRUPT_STATUS  = 8'hc7;

    // =========================================================
    // reset values
    localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
    localparam logic [7:0] RST_INTERRUPT_STATUS  = 8'h00;

    // =========================================================
    // field positions, shared by control and status
    localparam int BIT_INDIRECT_DONE  = 7;
    localparam int BIT_RECEIVER_FOUND = 6;
    localparam int BIT_DOWNSTREAM_IRQ = 5;
    localparam int BIT_KEY_LIST_READY = 4;
    localparam int BIT_KEY_READY      = 3;
    localparam int BIT_AUTH_FAIL      = 2;
    localparam int BIT_AUTH_PASS      = 1;
    localparam int BIT_GLOBAL         = 0;

    // =========================================================
    // event count and source order (index i maps to bit i+1)
    localparam int NUM_EVENTS = 7;

    // =========================================================
    // read data for an unmapped offset
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

endpackage

// *** lia_event_latch.sv ***
/*
 Sticky event latch for the interrupt aggregator sources.
 Assumes events are one-cycle or level pulses synchronous to clk and that
 the clear pulse marks a completed status read.
*/
`timescale 1ns/1ns
module lia_event_latch (
    // clock and reset
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    // events and clear
    input  wire logic [lia_pkg::NUM_EVENTS-1:0] event_in,
    input  wire logic [lia_pkg::NUM_EVENTS-1:0] clear_in,
    // held flags
    output logic      [lia_pkg::NUM_EVENTS-1:0] flag_out
);

    // =========================================================
    // sticky flags, set wins over clear
    logic [lia_pkg::NUM_EVENTS-1:0] flag_r;
    logic [lia_pkg::NUM_EVENTS-1:0] flag_nxt;

    always_comb begin
        flag_nxt = (flag_r & ~clear_in) | event_in;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= lia_pkg::RST_INTERRUPT_STATUS[lia_pkg::NUM_EVENTS:1];
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign flag_out = flag_r;

endmodule

// *** lia_link_interrupt_aggregator_sva.sv ***
/* Checker for the link interrupt aggregator.
   Sees only the top module ports; bound from the bench file. */
`timescale 1ns/1ns
module lia_link_interrupt_aggregator_sva (
    // clock and reset
    input wire logic       clk,
    input wire logic       reset_n,
    // register port
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid,
    // events and interrupt
    input wire logic       indirect_done,
    input wire logic       receiver_found,
    input wire logic       downstream_irq,
    input wire logic       key_list_ready,
    input wire logic       key_ready,
    input wire logic       auth_fail,
    input wire logic       auth_pass,
    input wire logic       irq_out
);
    // ==========================================================
    // control shadow and helpers
    logic [7:0] ctl_r;
    logic [7:1] ev;
    logic       rs;
    logic       rc;
    assign ev = {indirect_done, receiver_found, downstream_irq,
                 key_list_ready, key_ready, auth_fail, auth_pass};
    assign rs = reg_rd && reg_addr == lia_pkg::OFF_INTERRUPT_STATUS;
    assign rc = reg_rd && reg_addr == lia_pkg::OFF_INTERRUPT_CONTROL;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) ctl_r <= 8'h00;
        else if (reg_wr && reg_addr == lia_pkg::OFF_INTERRUPT_CONTROL)
            ctl_r <= reg_wdata;
    end
    // ==========================================================
    // assertions
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_irq_gated:
        assert property (irq_out |-> ctl_r[0] || $past(ctl_r[0]))
        else $error("irq without global enable");
    a_irq_drop:
        assert property ($fell(ctl_r[0]) |=> !irq_out)
        else $error("irq after global disable");
    a_irq_raise:
        assert property (ctl_r[0] && |(ev & ctl_r[7:1]) && !reg_wr
            |=> ##1 irq_out) else $error("enabled event gave no irq");
    a_flags_show:
        assert property ((|ev) ##1 rs
            |=> (reg_rdata[7:1] & $past(ev, 2)) == $past(ev, 2))
        else $error("event missing from status");
    a_flags_held:
        assert property ((|ev) ##1 !reg_rd [*2] ##1 rs
            |=> (reg_rdata[7:1] & $past(ev, 4)) == $past(ev, 4))
        else $error("flag lost before status read");
    a_summary_bit:
        assert property (rs |=> reg_rdata[0] ==
            |(reg_rdata[7:1] & $past(ctl_r[7:1])))
        else $error("summary bit wrong");
    a_flag_clear:
        assert property (rs && ev == 7'h00 |=> ##1 !irq_out)
        else $error("irq after status read");
    a_ctl_readback:
        assert property (rc |=> reg_rdata == $past(ctl_r))
        else $error("control read back wrong");
endmodule

// *** lia_host_model.sv ***
/* Host controller model: register writes and reads on the strobe port.
   Assumes each read is answered by a one-cycle valid pulse. */
`timescale 1ns/1ns
module lia_host_model (
    // clock
    input  wire logic       clk,
    // register port toward the block
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    task write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task read_reg(input logic [7:0] a, output logic [7:0] d,
                  output logic ok);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        for (int n = 0; n < 3 && reg_rvalid !== 1'b1; n++) @(posedge clk) #1;
        ok = reg_rvalid === 1'b1;
        d = reg_rdata;
    endtask
endmodule

// *** lia_link_interrupt_aggregator_bench.sv ***
/* Bench for the link interrupt aggregator: host model on the register
   port, events driven here; checker bound at the foot. */
`timescale 1ns/1ns
module lia_link_interrupt_aggregator_bench;
    localparam logic [7:0] C = lia_pkg::OFF_INTERRUPT_CONTROL;
    localparam logic [7:0] S = lia_pkg::OFF_INTERRUPT_STATUS;
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       reg_wr, reg_rd, reg_rvalid, irq_out;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, m;
    logic [6:0] ev = 7'h00;
    int         errors = 0;
    int         n_compared = 0;
    initial forever #4 clk = ~clk;
    lia_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));
    lia_link_interrupt_aggregator u_lia_link_interrupt_aggregator (
        .clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .indirect_done(ev[6]),
        .receiver_found(ev[5]), .downstream_irq(ev[4]),
        .key_list_ready(ev[3]), .key_ready(ev[2]), .auth_fail(ev[1]),
        .auth_pass(ev[0]), .irq_out(irq_out));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask
    task stop_test;
        $display("compared %0d mismatched %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       ok;
        host.read_reg(a, d, ok);
        if (!ok) begin
            errors++;
            stop_test();
        end else check(d, e);
    endtask
    task pulse(input logic [6:0] v);
        @(posedge clk) ev <= v;
        @(posedge clk) ev <= 7'h00;
    endtask
    task irq_chk(input logic e);
        @(posedge clk);
        #1;
        check({7'h00, irq_out}, {7'h00, e});
    endtask
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(C, lia_pkg::RST_INTERRUPT_CONTROL);
        rd_chk(S, lia_pkg::RST_INTERRUPT_STATUS);
        $display("reset test done");
        for (int i = 0; i < 7; i++) begin
            m = 8'h02 << i;
            host.write_reg(C, m | 8'h01);
            pulse(7'h01 << i);
            irq_chk(1'b1);
            rd_chk(S, m | 8'h01);
            rd_chk(S, 8'h00);
            irq_chk(1'b0);
        end
        $display("source test done");
        host.write_reg(C, 8'hfe);
        pulse(7'h7f);
        irq_chk(1'b0);
        rd_chk(S, 8'hff);
        host.write_reg(C, 8'h01);
        pulse(7'h7f);
        irq_chk(1'b0);
        rd_chk(S, 8'hfe);
        $display("gating test done");
        @(posedge clk) ev <= 7'h01;
        rd_chk(S, 8'h02);
        @(posedge clk) ev <= 7'h00;
        rd_chk(S, 8'h02);
        rd_chk(S, 8'h00);
        host.write_reg(S, 8'hff);
        host.write_reg(8'h10, 8'hff);
        rd_chk(C, 8'h01);
        rd_chk(S, 8'h00);
        rd_chk(8'h10, lia_pkg::RD_UNMAPPED);
        host.write_reg(C, 8'ha5);
        rd_chk(C, 8'ha5);
        $display("access test done");
        stop_test();
    end
endmodule
bind lia_link_interrupt_aggregator lia_link_interrupt_aggregator_sva u_sva (
    .clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .indirect_done(indirect_done),
    .receiver_found(receiver_found), .downstream_irq(downstream_irq),
    .key_list_ready(key_list_ready), .key_ready(key_ready),
    .auth_fail(auth_fail), .auth_pass(auth_pass), .irq_out(irq_out));
